// file: phy_packet_transmit_format_tb.sv
// Purpose: self-checking bench for the phy packet framer
// Assumes: 10 MHz sys_clk, synchronous active-low reset
// Notes: status compared with a bench model after each step
`include "phypk_map.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: %h not %h", $time, (a), (e)); end end
module phy_packet_transmit_format_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] NODE = 16'h0123;
    localparam logic [5:0] PHYS = 6'h05;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, bus_reset = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, tx_data, rx_first, rx_second, selfid_data, rd, lf = 32'd28925;
    logic pready, pslverr, tx_valid, tx_ready, rx_valid, phy_event_indication, selfid_valid, selfid_ready;
    logic root_pref, root = 0, pend = 0, hdr = 0, chk = 0, wake = 0, late = 0, txe = 0, refused = 0, err;
    logic [5:0] gap_count, gap = 6'h3F;
    logic [1:0] stall = 2'h0;
    logic [31:0] exq[$];
    int n_errors = 0, comparisons = 0, n_ev = 0, ev = 0;
    phypk_framer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_first(rx_first), .rx_second(rx_second), .bus_reset(bus_reset),
        .phy_event_indication(phy_event_indication), .selfid_valid(selfid_valid),
        .selfid_data(selfid_data), .selfid_ready(selfid_ready), .root_pref(root_pref), .gap_count(gap_count));
    ppt_phy_model phy (.sys_clk(sys_clk), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .selfid_valid(selfid_valid), .selfid_data(selfid_data),
        .selfid_ready(selfid_ready), .rx_valid(rx_valid), .rx_first(rx_first), .rx_second(rx_second));
    initial forever #50 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (phy_event_indication === 1'b1) n_ev++;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(negedge sys_clk);
            n++;
            if (n == 40 && stall == 2'h2) begin
                stall <= 2'h1;
                refused = 1'b1;
            end
        end while (pready !== 1'b1 && n < 300);
        rd = prdata;
        err = pslverr;
        @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 300) begin
            n_errors++;
            end_of_test;
        end
        @(posedge sys_clk);
    endtask
    task automatic push(input logic [31:0] a);
        apb(1'b1, `PHYPK_OFS_ATQ_FIRST, a);
        exq.push_back(a[15:0] == `PHYPK_MARK ? {a[31:16], `PHYPK_MARK_SUB} : a);
        apb(1'b1, `PHYPK_OFS_ATQ_SECOND, ~a);
        exq.push_back(~a);
    endtask
    task automatic st;
        apb(1'b0, `PHYPK_OFS_STATUS, 32'h0);
        `CHK(rd, {11'h0, txe, late, wake, chk, hdr, 7'h0, root, 2'h0, gap})
        apb(1'b1, `PHYPK_OFS_STATUS, 32'h001F_0000);
        {txe, late, wake, chk, hdr} = 5'h0;
    endtask
    task automatic rx(input logic [31:0] f, input logic bad);
        phy.send(f, bad ? ~f ^ 32'h1 : ~f);
        if (f[31:30] == `PHYPK_ID_CFG && f[31:16] == NODE) hdr = 1'b1;
        if (bad) chk = 1'b1;
        else if (f[31:30] == `PHYPK_ID_LINK_ON && f[29:24] == PHYS) begin
            wake = 1'b1;
            ev++;
        end else if (f[31:30] == `PHYPK_ID_CFG) begin
            if (f[23]) root = f[29:24] == PHYS;
            if (f[22]) begin
                gap = f[21:16];
                pend = 1'b1;
            end
        end
    endtask
    task automatic bres;
        bus_reset <= 1'b1;
        @(posedge sys_clk);
        bus_reset <= 1'b0;
        @(posedge sys_clk);
        if (pend) pend = 1'b0;
        else gap = `PHYPK_GAP_DEFAULT;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        st;
        apb(1'b1, `PHYPK_OFS_CTRL, {10'h0, PHYS, NODE});
        apb(1'b0, `PHYPK_OFS_CTRL, 32'h0);
        `CHK(rd, {10'h0, PHYS, NODE})
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        stall <= 2'h2;
        for (int i = 0; i < 18; i++) begin
            lf = lfsr(lf);
            push(i[0] ? {lf[31:16], `PHYPK_MARK} : lf);
        end
        `CHK(refused, 1'b1)
        for (int i = 0; i < 300 && phy.txq.size() < exq.size(); i++) @(posedge sys_clk);
        foreach (exq[i]) `CHK(phy.txq[i], exq[i])
        apb(1'b1, `PHYPK_OFS_ATQ_FIRST, 32'h1234_00E0);
        apb(1'b1, `PHYPK_OFS_ATQ_SECOND, 32'h0);
        txe = 1'b1;
        st;
        rx({2'h0, PHYS, 2'h3, 6'h0A, 16'h0}, 1'b0);
        st;
        rx({2'h0, 6'h09, 2'h2, 6'h11, 16'h0}, 1'b0);
        st;
        rx({2'h0, PHYS, 2'h0, 6'h21, 16'h0}, 1'b0);
        st;
        rx({NODE, 16'h0}, 1'b0);
        st;
        rx({2'h0, PHYS, 2'h3, 6'h02, 16'h0}, 1'b1);
        st;
        bres;
        st;
        bres;
        st;
        rx({2'h1, PHYS, 24'h0}, 1'b0);
        rx({2'h1, 6'h09, 24'h0}, 1'b0);
        st;
        `CHK(n_ev, ev)
        rx({2'h0, PHYS, 2'h3, 6'h0C, 16'h0}, 1'b0);
        rx({2'h0, PHYS, 24'h0}, 1'b0);
        repeat (12) @(posedge sys_clk);
        `CHK(phy.sidq[0], {2'h2, PHYS, 2'h1, gap, 15'h0, root})
        `CHK(phy.sidq[1], ~{2'h2, PHYS, 2'h1, gap, 15'h0, root})
        st;
        stall <= 2'h2;
        rx({2'h0, PHYS, 24'h0}, 1'b0);
        repeat (15) @(posedge sys_clk);
        stall <= 2'h0;
        late = 1'b1;
        repeat (5) @(posedge sys_clk);
        st;
        end_of_test;
    end
endmodule // phy_packet_transmit_format_tb

// file: phypk_fifo.v
// Purpose: transmit queue storage, flip-flop FIFO
// Assumes: single clock, synchronous active-low reset
// Notes: in_ready low while full, out_valid low while empty
module phypk_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // phypk_fifo

// file: phypk_framer.v
// Purpose: PHY packet framing on transmit and interpretation on receipt
// Assumes: APB slave at 10 MHz sys_clk; PHY side logic on the same clock
// Notes: transmit quadlets pass a FIFO toward the PHY
//
// The register offsets and the APB slave port were decided locally.
`include "phypk_map.vh"

module phypk_framer #(
    parameter FIFO_WIDTH = 32,
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW = 5
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // toward the phy transmitter
    output reg tx_valid,
    output reg [31:0] tx_data,
    input wire tx_ready,
    // received phy packets
    input wire rx_valid,
    input wire [31:0] rx_first,
    input wire [31:0] rx_second,
    input wire bus_reset,
    // link layer events and self-id answer
    output reg phy_event_indication,
    output reg selfid_valid,
    output reg [31:0] selfid_data,
    input wire selfid_ready,
    // present configuration
    output reg root_pref,
    output reg [5:0] gap_count
);
    reg [15:0] node_id;
    reg [5:0] phys_num;
    reg hdr_err;
    reg chk_err;
    reg wake_seen;
    reg ping_late;
    reg tx_chk_err;
    reg [31:0] tx_first_raw;
    reg gap_hold;
    reg gap_once;
    reg selfid_second;
    reg [7:0] resp_cnt;

    // self-id answer states
    localparam SID_IDLE = 3'b001;
    localparam SID_FIRST = 3'b010;
    localparam SID_SECOND = 3'b100;
    reg [2:0] sid_state;
    reg [2:0] next_sid_state;

    function mapped;
        input [7:0] addr;
        begin
            mapped = (addr == `PHYPK_OFS_CTRL) || (addr == `PHYPK_OFS_STATUS) ||
                     (addr == `PHYPK_OFS_ATQ_FIRST) || (addr == `PHYPK_OFS_ATQ_SECOND);
        end
    endfunction

    function is_queue;
        input [7:0] addr;
        begin
            is_queue = (addr == `PHYPK_OFS_ATQ_FIRST) || (addr == `PHYPK_OFS_ATQ_SECOND);
        end
    endfunction

    // apb access decode
    wire access = psel & penable & ~pready;
    wire fifo_in_ready;
    wire q_write = access & pwrite & is_queue(paddr);
    wire stall = q_write & ~fifo_in_ready;
    wire done = access & ~stall;
    wire wr_first = q_write & fifo_in_ready & (paddr == `PHYPK_OFS_ATQ_FIRST);
    wire wr_second = q_write & fifo_in_ready & (paddr == `PHYPK_OFS_ATQ_SECOND);
    wire wr_ctrl = done & pwrite & (paddr == `PHYPK_OFS_CTRL);
    wire wr_status = done & pwrite & (paddr == `PHYPK_OFS_STATUS);

    // marker swap on the first quadlet
    wire is_phy_pkt = (pwdata[15:0] == `PHYPK_MARK);
    wire [31:0] fifo_in_data = (wr_first && is_phy_pkt) ?
        {pwdata[31:16], `PHYPK_MARK_SUB} : pwdata;

    // transmit queue
    wire fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire fifo_out_ready = ~tx_valid | tx_ready;

    phypk_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_queue (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(wr_first | wr_second),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // receive field decode
    wire [1:0] rx_id = rx_first[`PHYPK_F_ID_MSB:`PHYPK_F_ID_LSB];
    wire [5:0] rx_phys = rx_first[`PHYPK_F_PHYS_MSB:`PHYPK_F_PHYS_LSB];
    wire rx_root = rx_first[`PHYPK_F_ROOT];
    wire rx_gapupd = rx_first[`PHYPK_F_GAPUPD];
    wire [5:0] rx_gap = rx_first[`PHYPK_F_GAP_MSB:`PHYPK_F_GAP_LSB];
    wire [3:0] rx_type = rx_first[`PHYPK_F_TYPE_MSB:`PHYPK_F_TYPE_LSB];
    wire rx_ok = rx_valid & (rx_second == ~rx_first);
    wire rx_mine = (rx_phys == phys_num);
    wire rx_cfg = rx_ok & (rx_id == `PHYPK_ID_CFG);
    wire set_root = rx_cfg & rx_root;
    wire set_gap = rx_cfg & rx_gapupd;
    wire rx_ping = rx_cfg & ~rx_root & ~rx_gapupd & (rx_type == `PHYPK_PING_TYPE) & rx_mine;
    wire rx_link_on = rx_ok & (rx_id == `PHYPK_ID_LINK_ON) & rx_mine;
    wire set_hdr = rx_valid & (rx_id == `PHYPK_ID_CFG) &
        (rx_first[`PHYPK_F_DEST_MSB:`PHYPK_F_DEST_LSB] == node_id);
    wire set_chk = rx_valid & ~(rx_second == ~rx_first);
    wire set_tx_chk = wr_second & (pwdata != ~tx_first_raw);
    wire set_late = (sid_state == SID_FIRST) & ~selfid_ready &
        (resp_cnt == `PHYPK_RESPONSE_CYCLES - 1);

    // control reset value, sliced per field
    wire [31:0] ctrl_rst = `PHYPK_CTRL_RESET;

    // status word
    wire [31:0] status_word = {11'h000, tx_chk_err, ping_late, wake_seen, chk_err, hdr_err,
                               7'h00, root_pref, 2'h0, gap_count};

    // apb slave
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= done;
            pslverr <= done & ~mapped(paddr);
            if (done && !pwrite && paddr == `PHYPK_OFS_CTRL) begin
                prdata <= {10'h000, phys_num, node_id};
            end else if (done && !pwrite && paddr == `PHYPK_OFS_STATUS) begin
                prdata <= status_word;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // control and sticky flags, set wins over clear
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            node_id <= ctrl_rst[`PHYPK_CTRL_NODE_MSB:`PHYPK_CTRL_NODE_LSB];
            phys_num <= ctrl_rst[`PHYPK_CTRL_PHYS_MSB:`PHYPK_CTRL_PHYS_LSB];
            hdr_err <= 1'b0;
            chk_err <= 1'b0;
            wake_seen <= 1'b0;
            ping_late <= 1'b0;
            tx_chk_err <= 1'b0;
            tx_first_raw <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                node_id <= pwdata[`PHYPK_CTRL_NODE_MSB:`PHYPK_CTRL_NODE_LSB];
                phys_num <= pwdata[`PHYPK_CTRL_PHYS_MSB:`PHYPK_CTRL_PHYS_LSB];
            end
            if (wr_first) begin
                tx_first_raw <= pwdata;
            end
            hdr_err <= set_hdr | (hdr_err & ~(wr_status & pwdata[`PHYPK_ST_HDR_ERR]));
            chk_err <= set_chk | (chk_err & ~(wr_status & pwdata[`PHYPK_ST_CHK_ERR]));
            wake_seen <= rx_link_on | (wake_seen & ~(wr_status & pwdata[`PHYPK_ST_WAKE]));
            ping_late <= set_late | (ping_late & ~(wr_status & pwdata[`PHYPK_ST_PING_LATE]));
            tx_chk_err <= set_tx_chk | (tx_chk_err & ~(wr_status & pwdata[`PHYPK_ST_TX_CHK_ERR]));
        end
    end

    // transmit output stage
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data <= 32'h0000_0000;
        end else if (fifo_out_ready) begin
            tx_valid <= fifo_out_valid;
            tx_data <= fifo_out_data;
        end
    end

    // configuration state: root preference and gap count
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            root_pref <= 1'b0;
            gap_count <= `PHYPK_GAP_DEFAULT;
            gap_hold <= 1'b0;
            gap_once <= 1'b0;
            phy_event_indication <= 1'b0;
        end else begin
            phy_event_indication <= rx_link_on;
            if (set_root) begin
                root_pref <= rx_mine;
            end
            if (set_gap) begin
                gap_count <= rx_gap;
                gap_hold <= 1'b1;
                gap_once <= 1'b0;
            end else if (bus_reset) begin
                if (gap_hold && !gap_once) begin
                    gap_once <= 1'b1;
                end else begin
                    gap_count <= `PHYPK_GAP_DEFAULT;
                    gap_hold <= 1'b0;
                    gap_once <= 1'b0;
                end
            end
        end
    end

    // self-id answer sequencing
    always @* begin
        case (sid_state)
            SID_IDLE: begin
                next_sid_state = rx_ping ? SID_FIRST : SID_IDLE;
            end
            SID_FIRST: begin
                next_sid_state = selfid_ready ? SID_SECOND : SID_FIRST;
            end
            SID_SECOND: begin
                next_sid_state = selfid_ready ? SID_IDLE : SID_SECOND;
            end
            default: begin
                next_sid_state = SID_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sid_state <= SID_IDLE;
            selfid_valid <= 1'b0;
            selfid_data <= 32'h0000_0000;
            selfid_second <= 1'b0;
            resp_cnt <= 8'h00;
        end else begin
            sid_state <= next_sid_state;
            case (sid_state)
                SID_IDLE: begin
                    resp_cnt <= 8'h00;
                    if (rx_ping) begin
                        selfid_valid <= 1'b1;
                        selfid_second <= 1'b0;
                        selfid_data <= {`PHYPK_ID_SELF_ID, phys_num, 2'h1, gap_count, 15'h0000, root_pref};
                    end
                end
                SID_FIRST: begin
                    if (selfid_ready) begin
                        selfid_second <= 1'b1;
                        selfid_data <= ~selfid_data;
                    end else if (resp_cnt != 8'hFF) begin
                        resp_cnt <= resp_cnt + 8'h01;
                    end
                end
                SID_SECOND: begin
                    if (selfid_ready) begin
                        selfid_valid <= 1'b0;
                        selfid_second <= 1'b0;
                    end
                end
                default: begin
                    selfid_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule // phypk_framer

// file: phypk_map.vh
// Purpose: offsets, field positions, reset values and timing counts of the PHY packet framer
// Assumes: byte addresses on a 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef PHYPK_MAP_VH
`define PHYPK_MAP_VH

// register byte offsets
`define PHYPK_OFS_CTRL 8'h00
`define PHYPK_OFS_STATUS 8'h04
`define PHYPK_OFS_ATQ_FIRST 8'h70
`define PHYPK_OFS_ATQ_SECOND 8'h78

// control word fields
`define PHYPK_CTRL_NODE_LSB 0
`define PHYPK_CTRL_NODE_MSB 15
`define PHYPK_CTRL_PHYS_LSB 16
`define PHYPK_CTRL_PHYS_MSB 21
`define PHYPK_CTRL_RESET 32'h0000_0000

// status word fields
`define PHYPK_ST_GAP_LSB 0
`define PHYPK_ST_GAP_MSB 5
`define PHYPK_ST_ROOT 8
`define PHYPK_ST_HDR_ERR 16
`define PHYPK_ST_CHK_ERR 17
`define PHYPK_ST_WAKE 18
`define PHYPK_ST_PING_LATE 19
`define PHYPK_ST_TX_CHK_ERR 20

// marker in the first quadlet and its substitute
`define PHYPK_MARK 16'h00E0
`define PHYPK_MARK_SUB 16'h0000

// packet identifier codes
`define PHYPK_ID_CFG 2'h0
`define PHYPK_ID_LINK_ON 2'h1
`define PHYPK_ID_SELF_ID 2'h2
`define PHYPK_PING_TYPE 4'h0

// first quadlet field positions
`define PHYPK_F_ID_MSB 31
`define PHYPK_F_ID_LSB 30
`define PHYPK_F_PHYS_MSB 29
`define PHYPK_F_PHYS_LSB 24
`define PHYPK_F_ROOT 23
`define PHYPK_F_GAPUPD 22
`define PHYPK_F_GAP_MSB 21
`define PHYPK_F_GAP_LSB 16
`define PHYPK_F_TYPE_MSB 21
`define PHYPK_F_TYPE_LSB 18
`define PHYPK_F_DEST_MSB 31
`define PHYPK_F_DEST_LSB 16

// gap count reset value
`define PHYPK_GAP_DEFAULT 6'h3F

// timing
`define PHYPK_CLK_PERIOD_NS 100
`define PHYPK_RESPONSE_TIME_NS 1000
`define PHYPK_RESPONSE_CYCLES (`PHYPK_RESPONSE_TIME_NS / `PHYPK_CLK_PERIOD_NS)

`endif

// file: ppt_chk.sv
// Purpose: port assertions for the phy packet framer
// Assumes: one clock, rst_n synchronous active low
// Notes: bound to phypk_framer below
module ppt_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // phy side
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [31:0] rx_first,
    input wire logic [31:0] rx_second,
    input wire logic bus_reset,
    // events and state
    input wire logic phy_event_indication,
    input wire logic selfid_valid,
    input wire logic [31:0] selfid_data,
    input wire logic selfid_ready,
    input wire logic root_pref,
    input wire logic [5:0] gap_count
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire good = rx_valid && rx_second == ~rx_first;
    wire cfg = good && rx_first[31:30] == 2'h0;
    sequence s_tx_wait;
        tx_valid && !tx_ready;
    endsequence
    sequence s_tx_keep;
        tx_valid && $stable(tx_data);
    endsequence
    access_end_a: assert property (pready |-> $past(psel && penable) ##1 !pready)
        else $error("pready without access or too long");
    tx_hold_a: assert property (s_tx_wait |=> s_tx_keep)
        else $error("tx quadlet dropped or changed");
    wake_cause_a: assert property (phy_event_indication |-> $past(good && rx_first[31:30] == 2'h1)
        ##1 !phy_event_indication) else $error("event without link-on");
    gap_load_a: assert property (cfg && rx_first[22] |=> gap_count == $past(rx_first[21:16]))
        else $error("gap count not loaded");
    gap_source_a: assert property (!$stable(gap_count) |-> $past(rx_valid || bus_reset || !rst_n))
        else $error("gap count changed by itself");
    root_cause_a: assert property (!$stable(root_pref) |-> $past(cfg && rx_first[23] || !rst_n))
        else $error("root preference changed by itself");
    reserved_cfg_a: assert property (cfg && !rx_first[23] && !rx_first[22] && !bus_reset
        |=> $stable(gap_count) && $stable(root_pref)) else $error("reserved packet acted on");
    sid_first_a: assert property ($rose(selfid_valid) |-> selfid_data[31:30] == 2'h2 && $past(good))
        else $error("self-id answer without ping");
    sid_pair_a: assert property (selfid_valid && selfid_ready && selfid_data[31:30] == 2'h2
        |=> selfid_valid && selfid_data == ~$past(selfid_data)) else $error("no inverse word");
endmodule // ppt_chk

bind phypk_framer ppt_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_first(rx_first), .rx_second(rx_second), .bus_reset(bus_reset),
    .phy_event_indication(phy_event_indication), .selfid_valid(selfid_valid),
    .selfid_data(selfid_data), .selfid_ready(selfid_ready), .root_pref(root_pref), .gap_count(gap_count));

// file: ppt_phy_model.sv
// Purpose: phy side stand-in, takes quadlets and sends packets
// Assumes: same clock as the framer
// Notes: stall 0 ready, 1 tx toggling and self-id ready, 2 never ready
module ppt_phy_model (
    // clock and pacing
    input wire logic sys_clk,
    input wire logic [1:0] stall,
    // transmit and self-id sinks
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    output logic tx_ready = 1'b0,
    input wire logic selfid_valid,
    input wire logic [31:0] selfid_data,
    output logic selfid_ready = 1'b0,
    // received packets
    output logic rx_valid = 1'b0,
    output logic [31:0] rx_first = 32'h0,
    output logic [31:0] rx_second = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] txq[$];
    logic [31:0] sidq[$];
    always @(posedge sys_clk) begin
        tx_ready <= stall == 2'h0 || (stall == 2'h1 && !tx_ready);
        selfid_ready <= stall != 2'h2;
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (selfid_valid && selfid_ready) sidq.push_back(selfid_data);
    end
    // one packet for one cycle, idle lines inverted afterwards
    task automatic send(input logic [31:0] f, input logic [31:0] s);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_first <= f;
        rx_second <= s;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_first <= ~f;
        rx_second <= ~s;
    endtask
endmodule // ppt_phy_model
